//--- rtl/dac_trigger_wave_control.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R01: channel_power_on bit powers the converter; analog wake-up follows.
// R02: output buffer on from reset, off only while buffer_disable set.
// R03: with buffer off, pin_disconnect_select routes output to comparator only.
// R04: any of three data registers updates the single 12-bit holding value.
// R05: 8-bit write sets upper eight bits, lower four forced zero.
// R06: conversion on soft trigger or rising external edge, only if enabled.
// R07: select: 0 timer1, 1 timer2, 4 timer6, 5 timer5, 6 line9, 7 soft.
// R08: setting soft trigger bit raises a software trigger event.
// R09: triggers enabled: holding copied to output only on selected trigger.
// R10: triggers disabled: holding copied to output after each data write.
// R11: wave mode field picks noise kind; width field sets amplitude.
// R12: noise mode adds lfsr output to holding value into output.
// R13: width below 12 keeps only that many low lfsr bits.
// R14: triangle mode adds triangle from 0 to (2<<width)-1.
// R15: with triggers and dma enabled, hardware trigger raises dma request.
// R16: hardware trigger while request pending sets underrun, is not serviced.
// R17: interrupt when underrun flag and underrun interrupt enable both set.
// R18: underrun withholds dma requests until software clears the flag.
// R19: wave mode 00 none, 01 noise, 1x triangle.
// R20: width code n means n+1 bits; 1011 and above mean 12.
// R21: left-aligned data in bits 15:4, right-aligned in bits 11:0.
// R22: noise source steps once per triggered transfer with a wave mode.
module dac_trigger_wave_control
  import wave_ctrl_pkg::*;
(
  input  wire logic                               clk_in,
  input  wire logic                               rst_n_in,
  input  wire logic [wave_ctrl_pkg::ADDR_W-1:0]   avs_address_in,
  input  wire logic                               avs_read_in,
  input  wire logic                               avs_write_in,
  input  wire logic [31:0]                        avs_writedata_in,
  input  wire logic [3:0]                         avs_byteenable_in,
  output logic      [31:0]                        avs_readdata_out,
  output logic                                    avs_waitrequest_out,
  input  wire logic                               timer_one_trigger_out_in,
  input  wire logic                               timer_two_trigger_out_in,
  input  wire logic                               timer_five_trigger_out_in,
  input  wire logic                               timer_six_trigger_out_in,
  input  wire logic                               external_line_nine_in,
  input  wire logic                               dma_ack_in,
  output logic                                    dma_req_out,
  output logic                                    irq_out,
  output logic                                    channel_power_on_out,
  output logic                                    buffer_enable_out,
  output logic                                    pin_connect_out,
  output logic                                    comparator_connect_out,
  output logic      [11:0]                        output_value_out
);
  import wave_ctrl_pkg::*;

  typedef struct packed {
    logic [14:0] control;
    logic [11:0] holding_value;
    logic [11:0] output_value;
    logic        dma_underrun_flag;
    logic        dma_req;
    logic        ext_prev;
    logic        ack_done;
    logic        write_pending;
    logic [31:0] rdata;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic        trigger_enable;
  logic [2:0]  trigger_source_select;
  logic [1:0]  wave_mode_select;
  logic [3:0]  wave_width_select;
  logic        dma_request_enable;
  logic        underrun_irq_enable;
  logic        buffer_disable;
  logic        pin_disconnect_select;
  logic        ext_level;
  logic        hw_edge;
  logic        soft_trigger_bit;
  logic        soft_event;
  logic        trig_event;
  logic        transfer;
  logic        wr_access;
  logic        rd_access;
  logic [3:0]  word_idx;
  logic [11:0] noise;
  logic [12:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // control field views
  assign trigger_enable        = state_reg.control[BIT_TRIG_EN];
  assign trigger_source_select = state_reg.control[POS_TRIG_SEL +: 3];
  assign wave_mode_select      = state_reg.control[POS_WAVE_MODE +: 2];
  assign wave_width_select     = state_reg.control[POS_WAVE_WIDTH +: 4];
  assign dma_request_enable    = state_reg.control[BIT_DMA_EN];
  assign underrun_irq_enable   = state_reg.control[BIT_UDR_IRQ_EN];
  assign buffer_disable        = state_reg.control[BIT_BUF_DISABLE];
  assign pin_disconnect_select = state_reg.control[BIT_PIN_DISC];

  // bus decode: word-aligned byte addresses, one wait state on reads
  assign word_idx  = avs_address_in[5:2];
  assign wr_access = avs_write_in;
  assign rd_access = avs_read_in && state_reg.ack_done;
  assign avs_waitrequest_out = avs_read_in && !state_reg.ack_done;

  ////////////////////////////////////////////////////////////////////////////
  // external trigger mux; reserved codes never fire
  always_comb begin
    unique case (trigger_source_select) // see R07
      SEL_TIMER_ONE:  ext_level = timer_one_trigger_out_in;
      SEL_TIMER_TWO:  ext_level = timer_two_trigger_out_in;
      SEL_TIMER_SIX:  ext_level = timer_six_trigger_out_in;
      SEL_TIMER_FIVE: ext_level = timer_five_trigger_out_in;
      SEL_EXT_NINE:   ext_level = external_line_nine_in;
      default:        ext_level = 1'b0;
    endcase
  end

  // rising edge only, and only while triggering is enabled
  assign hw_edge = trigger_enable && ext_level && !state_reg.ext_prev
                 && (trigger_source_select != SEL_SOFT); // see R06
  assign soft_trigger_bit = wr_access && (word_idx == OFS_SOFT_TRIGGER)
                          && avs_byteenable_in[0] && avs_writedata_in[0];
  assign soft_event = trigger_enable && soft_trigger_bit
                    && (trigger_source_select == SEL_SOFT); // see R08

  // hardware trigger while a request still waits is not serviced
  assign trig_event = soft_event || (hw_edge && !(dma_request_enable
                    && (state_reg.dma_req || state_reg.dma_underrun_flag)));
  assign transfer   = trigger_enable ? trig_event
                                     : state_reg.write_pending; // see R09, R10

  noise_wave_gen u_noise (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .step_in       (transfer && trigger_enable && wave_mode_select != 2'h0),
    .mode_in       (trigger_enable ? wave_mode_select : 2'h0), // see R11, R19
    .width_code_in (wave_width_select),
    .noise_out     (noise)
  );

  // saturate so noise never wraps the code around
  assign sum = {1'b0, state_reg.holding_value} + {1'b0, noise}; // see R12, R14

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next               = state_reg;
    state_next.ext_prev      = ext_level;
    state_next.write_pending = 1'b0;
    state_next.ack_done      = avs_read_in && !state_reg.ack_done;
    if (wr_access && avs_byteenable_in[0]) begin
      unique case (word_idx)
        OFS_CONTROL: begin
          state_next.control = avs_writedata_in[14:0] & CONTROL_MASK;
        end
        OFS_RIGHT12: begin
          if (avs_byteenable_in[1]) begin
            state_next.holding_value = avs_writedata_in[11:0]; // see R04, R21
            state_next.write_pending = 1'b1;
          end
        end
        OFS_LEFT12: begin
          if (avs_byteenable_in[1]) begin
            state_next.holding_value = avs_writedata_in[15:4]; // see R04, R21
            state_next.write_pending = 1'b1;
          end
        end
        OFS_RIGHT8: begin
          state_next.holding_value = {avs_writedata_in[7:0], 4'h0}; // see R05
          state_next.write_pending = 1'b1;
        end
        OFS_STATUS: begin
          if (avs_writedata_in[BIT_UNDERRUN]) begin // write one to clear
            state_next.dma_underrun_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (transfer) begin
      state_next.output_value = sum[12] ? 12'hfff : sum[11:0];
    end
    // dma request raised on hardware triggers only
    if (dma_ack_in) begin
      state_next.dma_req = 1'b0;
    end
    if (trigger_enable && dma_request_enable && hw_edge) begin // see R15
      if (state_reg.dma_req) begin
        state_next.dma_underrun_flag = 1'b1; // see R16
      end else if (!state_reg.dma_underrun_flag) begin
        state_next.dma_req = 1'b1; // see R18
      end
    end
    // read data captured in the wait cycle
    unique case (word_idx)
      OFS_CONTROL: state_next.rdata = {17'h0, state_reg.control};
      OFS_OUTPUT:  state_next.rdata = {20'h0, state_reg.output_value};
      OFS_RIGHT12: state_next.rdata = {20'h0, state_reg.holding_value};
      OFS_LEFT12:  state_next.rdata = {16'h0, state_reg.holding_value, 4'h0};
      OFS_RIGHT8:  state_next.rdata = {24'h0, state_reg.holding_value[11:4]};
      OFS_STATUS:  state_next.rdata = {18'h0, state_reg.dma_underrun_flag,
                                       13'h0};
      default:     state_next.rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{control: CONTROL_RESET, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; analog wake-up is left to software timing
  assign avs_readdata_out       = state_reg.rdata;
  assign dma_req_out            = state_reg.dma_req;
  assign irq_out                = state_reg.dma_underrun_flag
                                && underrun_irq_enable; // see R17
  assign channel_power_on_out   = state_reg.control[BIT_POWER_ON]; // see R01
  assign buffer_enable_out      = !buffer_disable; // see R02
  assign pin_connect_out        = !(buffer_disable
                                && pin_disconnect_select); // see R03
  assign comparator_connect_out = 1'b1;
  assign output_value_out       = state_reg.output_value;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_untrig_copy;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!trigger_enable && state_reg.write_pending)
      |=> (output_value_out == $past(state_reg.holding_value));
  endproperty
  a_untrig_copy: assert property (p_untrig_copy) // see R10
    else $error("holding value not copied after write");

  property p_r8_low;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_access && word_idx == OFS_RIGHT8 && avs_byteenable_in[0])
      |=> (state_reg.holding_value[3:0] == 4'h0);
  endproperty
  a_r8_low: assert property (p_r8_low) // see R05
    else $error("low bits not zero after 8-bit write");

  property p_hold_no_trig;
    @(posedge clk_in) disable iff (!rst_n_in)
    (trigger_enable && !transfer && $stable(trigger_enable))
      |=> $stable(output_value_out);
  endproperty
  a_hold_no_trig: assert property (p_hold_no_trig) // see R09
    else $error("output changed without trigger");

  property p_underrun_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    (dma_request_enable && trigger_enable && hw_edge && dma_req_out
      && !dma_ack_in) |=> state_reg.dma_underrun_flag;
  endproperty
  a_underrun_set: assert property (p_underrun_set) // see R16
    else $error("underrun not flagged");

  property p_no_req_after_udr;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg.dma_underrun_flag && !dma_req_out) |=> !dma_req_out;
  endproperty
  a_no_req_after_udr: assert property (p_no_req_after_udr) // see R18
    else $error("request during underrun");

  property p_soft_no_dma;
    @(posedge clk_in) disable iff (!rst_n_in)
    (soft_event && !dma_req_out && !hw_edge) |=> !dma_req_out;
  endproperty
  a_soft_no_dma: assert property (p_soft_no_dma) // see R15
    else $error("dma request on soft trigger");

  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
    (underrun_irq_enable && dma_request_enable && hw_edge && dma_req_out
      && !(wr_access && word_idx == OFS_CONTROL)) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) // see R17
    else $error("interrupt missing after underrun");

  property p_buffer;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_access && word_idx == OFS_CONTROL && avs_byteenable_in[0])
      |=> (buffer_enable_out == !$past(avs_writedata_in[BIT_BUF_DISABLE]));
  endproperty
  a_buffer: assert property (p_buffer) // see R02
    else $error("buffer enable wrong");

  property p_ext_edge;
    @(posedge clk_in) disable iff (!rst_n_in)
    (trigger_enable && trigger_source_select == SEL_TIMER_ONE
      && $stable(trigger_source_select)
      && $rose(timer_one_trigger_out_in)) |-> hw_edge;
  endproperty
  a_ext_edge: assert property (p_ext_edge) // see R06
    else $error("rising edge not taken as trigger");

  // both lanes needed, value lands in bits 11:0
  property p_right12;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_access && word_idx == OFS_RIGHT12 && avs_byteenable_in[1:0] == 2'h3)
      |=> (state_reg.holding_value == $past(avs_writedata_in[11:0]));
  endproperty
  a_right12: assert property (p_right12) // see R21
    else $error("right-aligned data misplaced");

  property p_left12;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_access && word_idx == OFS_LEFT12 && avs_byteenable_in[1:0] == 2'h3)
      |=> (state_reg.holding_value == $past(avs_writedata_in[15:4]));
  endproperty
  a_left12: assert property (p_left12) // see R21
    else $error("left-aligned data misplaced");

  property p_r8_high;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_access && word_idx == OFS_RIGHT8 && avs_byteenable_in[0])
      |=> (state_reg.holding_value[11:4] == $past(avs_writedata_in[7:0]));
  endproperty
  a_r8_high: assert property (p_r8_high) // see R05
    else $error("8-bit data not in upper bits");

  // a request stands until the controller answers
  property p_req_stands;
    @(posedge clk_in) disable iff (!rst_n_in)
    (dma_req_out && !dma_ack_in) |=> dma_req_out;
  endproperty
  a_req_stands: assert property (p_req_stands) // see R15
    else $error("request dropped before acknowledge");

  // saturating sum never falls below the holding value
  property p_no_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
    transfer |=> (output_value_out >= $past(state_reg.holding_value));
  endproperty
  a_no_wrap: assert property (p_no_wrap) // see R12
    else $error("output wrapped below holding value");

  property p_reserved_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
    (trigger_source_select[2:1] == 2'h1) |-> !hw_edge;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) // see R07
    else $error("reserved source fired");

  // a held read completes after exactly one wait state
  property p_read_wait;
    @(posedge clk_in) disable iff (!rst_n_in)
    (avs_read_in && avs_waitrequest_out) |=> (!avs_read_in || rd_access);
  endproperty
  a_read_wait: assert property (p_read_wait) // see R04
    else $error("read wait state too long");

endmodule : dac_trigger_wave_control
`default_nettype wire

//--- rtl/noise_wave_gen.sv
`timescale 1ns/1ns
`default_nettype none
// noise and triangle source; steps once per triggered transfer with a wave mode
module noise_wave_gen
  import wave_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        step_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [3:0]  width_code_in,
  output logic      [11:0] noise_out
);
  import wave_ctrl_pkg::*;

  typedef struct packed {
    logic [11:0] lfsr;
    logic [11:0] tri_val;
    logic        tri_down;
  } gen_state_t;

  gen_state_t state_reg;
  gen_state_t state_next;
  logic [11:0] mask;
  logic [11:0] tri_max;
  logic        fb;

  ////////////////////////////////////////////////////////////////////////////
  // width decode: code n gives n+1 bits, capped at 12
  always_comb begin
    mask = 12'hfff;
    if (width_code_in < WIDTH_FULL_CODE) begin // see R20
      mask = 12'((13'h2 << width_code_in) - 13'h1);
    end
  end
  assign tri_max = mask; // see R14

  // taps 12,6,4,1; seed nonzero so the sequence never locks up
  assign fb = state_reg.lfsr[11] ^ state_reg.lfsr[5]
            ^ state_reg.lfsr[3] ^ state_reg.lfsr[0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    if (step_in) begin // see R22
      if (mode_in == 2'h1) begin
        state_next.lfsr = {state_reg.lfsr[10:0], fb};
      end else if (mode_in[1]) begin
        if (!state_reg.tri_down) begin
          if (state_reg.tri_val >= tri_max) begin
            state_next.tri_down = 1'b1;
            state_next.tri_val  = state_reg.tri_val - 12'h1;
          end else begin
            state_next.tri_val = state_reg.tri_val + 12'h1;
          end
        end else begin
          if (state_reg.tri_val == 12'h0) begin
            state_next.tri_down = 1'b0;
            state_next.tri_val  = 12'h1;
          end else begin
            state_next.tri_val = state_reg.tri_val - 12'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{lfsr: LFSR_SEED, tri_val: 12'h0, tri_down: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // masked lfsr bits or clamped triangle
  always_comb begin
    noise_out = 12'h0;
    if (mode_in == 2'h1) begin
      noise_out = state_reg.lfsr & mask; // see R12, R13
    end else if (mode_in[1]) begin
      noise_out = (state_reg.tri_val > tri_max) ? tri_max
                                                : state_reg.tri_val;
    end
  end

endmodule : noise_wave_gen
`default_nettype wire

//--- rtl/wave_ctrl_pkg.sv
package wave_ctrl_pkg;

  // register word offsets on the avalon slave, taken from byte address bits 5:2
  localparam logic [3:0] OFS_CONTROL      = 4'h0;
  localparam logic [3:0] OFS_SOFT_TRIGGER = 4'h1;
  localparam logic [3:0] OFS_RIGHT12      = 4'h2;
  localparam logic [3:0] OFS_LEFT12       = 4'h3;
  localparam logic [3:0] OFS_RIGHT8       = 4'h4;
  localparam logic [3:0] OFS_OUTPUT       = 4'h5;
  localparam logic [3:0] OFS_STATUS       = 4'h6;
  localparam int         ADDR_W           = 6;

  // control register field positions, and the status underrun bit
  localparam int BIT_POWER_ON    = 0;
  localparam int BIT_BUF_DISABLE = 1;
  localparam int BIT_TRIG_EN     = 2;
  localparam int POS_TRIG_SEL    = 3;
  localparam int POS_WAVE_MODE   = 6;
  localparam int POS_WAVE_WIDTH  = 8;
  localparam int BIT_DMA_EN      = 12;
  localparam int BIT_UDR_IRQ_EN  = 13;
  localparam int BIT_PIN_DISC    = 14;
  localparam int BIT_UNDERRUN    = 13;
  localparam logic [14:0] CONTROL_RESET = 15'h0000;
  localparam logic [14:0] CONTROL_MASK  = 15'h7fff;

  // trigger source codes
  localparam logic [2:0] SEL_TIMER_ONE  = 3'h0;
  localparam logic [2:0] SEL_TIMER_TWO  = 3'h1;
  localparam logic [2:0] SEL_TIMER_SIX  = 3'h4;
  localparam logic [2:0] SEL_TIMER_FIVE = 3'h5;
  localparam logic [2:0] SEL_EXT_NINE   = 3'h6;
  localparam logic [2:0] SEL_SOFT       = 3'h7;

  // wave width code at and above which the full width applies
  localparam logic [3:0] WIDTH_FULL_CODE = 4'hb;
  localparam logic [11:0] LFSR_SEED      = 12'haaa;

endpackage : wave_ctrl_pkg

//--- tb/dac_trigger_wave_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dac_trigger_wave_control_bench;
  import wave_ctrl_pkg::*;
  logic        clk_in, rst_n_in, rd, wr, ack, req, irq, stall;
  logic        pwr, buf_en, pin_con, cmp_con, wait_rq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [4:0]  trig;
  logic [3:0]  be;
  logic [11:0] out_val;
  int          fails, num_checks;

  dac_trigger_wave_control DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
    .timer_one_trigger_out_in(trig[0]), .timer_two_trigger_out_in(trig[1]),
    .timer_six_trigger_out_in(trig[2]), .timer_five_trigger_out_in(trig[3]),
    .external_line_nine_in(trig[4]), .dma_ack_in(ack), .dma_req_out(req),
    .irq_out(irq), .channel_power_on_out(pwr), .buffer_enable_out(buf_en),
    .pin_connect_out(pin_con), .comparator_connect_out(cmp_con),
    .output_value_out(out_val));
  dma_partner partner (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .dma_req_in(req), .stall_in(stall), .delay_in(4'h2), .dma_ack_out(ack));

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest seen low
  task automatic bus(input logic w, input logic [3:0] ofs,
                     input logic [31:0] d, output logic [31:0] r);
    addr <= {ofs, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk_in);
    end while (wait_rq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (3) @(posedge clk_in); // lets transfers to output land
  endtask : bus

  function automatic logic [31:0] cw(input logic te, input logic [2:0] s,
                                     input logic [1:0] m, input logic [3:0] w);
    return (32'(te) << BIT_TRIG_EN) | (32'(s) << POS_TRIG_SEL) |
           (32'(m) << POS_WAVE_MODE) | (32'(w) << POS_WAVE_WIDTH);
  endfunction : cw

  // level held two samples so the edge detector sees one rise
  task automatic pulse(input int i);
    trig[i] <= 1'b1;
    repeat (2) @(posedge clk_in);
    trig[i] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({pwr, buf_en, pin_con, cmp_con, req, irq}, 6'b011100);
    chk(out_val, 12'h000);
    bus(1'b0, OFS_CONTROL, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_reset

  task automatic t_pins;
    bus(1'b1, OFS_CONTROL, 32'h1 << BIT_POWER_ON, q);
    chk(pwr, 1'b1);
    bus(1'b1, OFS_CONTROL, 32'h1 << BIT_PIN_DISC, q);
    chk({buf_en, pin_con}, 2'b11);
    bus(1'b1, OFS_CONTROL, 32'h1 << BIT_BUF_DISABLE, q);
    chk({buf_en, pin_con}, 2'b01);
    bus(1'b1, OFS_CONTROL, 32'h3 << BIT_BUF_DISABLE | 32'h1 << BIT_PIN_DISC, q);
    chk({buf_en, pin_con, cmp_con}, 3'b001);
    bus(1'b0, OFS_CONTROL, 32'h0, q);
    chk(q, 32'h4006);
  endtask : t_pins

  // triggers off: every data format moves straight to the output
  task automatic t_data;
    bus(1'b1, OFS_CONTROL, 32'h0, q);
    bus(1'b1, OFS_RIGHT12, 32'h123, q);
    chk(out_val, 12'h123);
    bus(1'b1, OFS_LEFT12, 32'habc0, q);
    chk(out_val, 12'habc);
    bus(1'b1, OFS_RIGHT8, 32'h5a, q);
    chk(out_val, 12'h5a0);
    be <= 4'h1;
    bus(1'b1, OFS_RIGHT12, 32'h777, q);
    be <= 4'hf;
    chk(out_val, 12'h5a0);
    bus(1'b0, 4'hf, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_data

  task automatic t_trig;
    logic [2:0] sel [5];
    sel = '{SEL_TIMER_ONE, SEL_TIMER_TWO, SEL_TIMER_SIX, SEL_TIMER_FIVE,
            SEL_EXT_NINE};
    bus(1'b1, OFS_CONTROL, cw(1'b1, SEL_SOFT, 2'b00, 4'h0), q);
    bus(1'b1, OFS_RIGHT12, 32'h321, q);
    chk(out_val, 12'h5a0);
    bus(1'b1, OFS_SOFT_TRIGGER, 32'h1, q);
    chk(out_val, 12'h321);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_CONTROL, cw(1'b1, sel[i], 2'b00, 4'h0), q);
      bus(1'b1, OFS_RIGHT12, 32'(12'h100 + i), q);
      pulse((i + 1) % 5);
      chk(out_val, (i == 0) ? 32'h321 : 32'(12'h0ff + i));
      pulse(i);
      chk(out_val, 32'(12'h100 + i));
    end
    bus(1'b1, OFS_CONTROL, cw(1'b1, 3'h2, 2'b00, 4'h0), q);
    for (int i = 0; i < 5; i++) pulse(i);
    chk(out_val, 12'h104);
  endtask : t_trig

  task automatic t_dma;
    logic [31:0] c;
    c = cw(1'b1, SEL_TIMER_ONE, 2'b00, 4'h0) | 32'h3 << BIT_DMA_EN;
    stall <= 1'b1;
    bus(1'b1, OFS_CONTROL, c, q);
    bus(1'b1, OFS_RIGHT12, 32'h111, q);
    pulse(0);
    chk({req, out_val}, 13'h1111);
    bus(1'b1, OFS_RIGHT12, 32'h222, q);
    pulse(0);
    chk({irq, out_val}, 13'h1111);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q, 32'h1 << BIT_UNDERRUN);
    bus(1'b1, OFS_CONTROL, c & ~(32'h1 << BIT_UDR_IRQ_EN), q);
    chk(irq, 1'b0);
    bus(1'b1, OFS_CONTROL, c, q);
    chk(irq, 1'b1);
    stall <= 1'b0;
    repeat (8) @(posedge clk_in);
    pulse(0);
    chk({req, out_val}, 13'h0111);
    bus(1'b1, OFS_STATUS, 32'h1 << BIT_UNDERRUN, q);
    chk(irq, 1'b0);
    pulse(0);
    chk(out_val, 12'h222);
    repeat (8) @(posedge clk_in);
    chk(req, 1'b0);
    bus(1'b1, OFS_CONTROL, c | cw(1'b1, SEL_SOFT, 2'b00, 4'h0), q);
    bus(1'b1, OFS_SOFT_TRIGGER, 32'h1, q);
    chk(req, 1'b0);
  endtask : t_dma

  // eight soft steps; offset above holding stays within the amplitude
  task automatic t_wave(input logic [1:0] m, input logic [3:0] w,
                        input logic [11:0] top);
    logic [11:0] d, hi, first;
    int moved;
    moved = 0;
    hi = 12'h000;
    bus(1'b1, OFS_CONTROL, cw(1'b1, SEL_SOFT, m, w), q);
    bus(1'b1, OFS_RIGHT12, 32'h400, q);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_SOFT_TRIGGER, 32'h1, q);
      d = out_val - 12'h400;
      if (i == 0) first = d;
      if (d !== first) moved = 1;
      if (d > hi) hi = d;
      chk(d <= top, 1'b1);
    end
    chk(moved, top != 0);
    if (m[1]) chk(hi, top);
  endtask : t_wave

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    summarize();
  end

  initial begin
    {rst_n_in, rd, wr, stall, trig, addr, wdata} = '0;
    fails = 0;
    num_checks = 0;
    be = 4'hf;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_pins();
    t_data();
    t_trig();
    t_dma();
    t_wave(2'b00, 4'h3, 12'h000);
    t_wave(2'b01, 4'h0, 12'h001);
    t_wave(2'b01, 4'h2, 12'h007);
    t_wave(2'b10, 4'h0, 12'h001);
    t_wave(2'b11, 4'h1, 12'h003);
    summarize();
  end
endmodule : dac_trigger_wave_control_bench
`default_nettype wire

//--- tb/dma_partner.sv
`timescale 1ns/1ns
`default_nettype none
// dma controller stand-in: answers promptly or slowly, or stalls
module dma_partner (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       dma_req_in,
  input  wire logic       stall_in,
  input  wire logic [3:0] delay_in,
  output logic            dma_ack_out
);
  logic [3:0] wait_reg;
  //////////////////////////////////////////////////////////////////////////
  // count request cycles; while stalled the request stays pending
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg    <= 4'h0;
      dma_ack_out <= 1'b0;
    end else if (dma_req_in && !stall_in && !dma_ack_out) begin
      dma_ack_out <= (wait_reg >= delay_in);
      wait_reg    <= wait_reg + 4'h1;
    end else begin
      wait_reg    <= 4'h0;
      dma_ack_out <= 1'b0;
    end
  end
endmodule : dma_partner
`default_nettype wire
